// ===== src/spi_flash_regs.svh
// opcodes, dummy counts and link timing for the serial flash front end
// assumes it is included by bare name from the package and both ends
`ifndef SPI_FLASH_REGS_SVH
`define SPI_FLASH_REGS_SVH

`define OP_READ 8'h03
`define OP_FAST 8'h0b
`define OP_DUAL_OUT 8'h3b
`define OP_DUAL_IO 8'hbb
`define OP_QUAD_IO 8'heb
`define OP_QUAD_OUT 8'h6b
`define OP_QUAD_PROG 8'h32
`define OP_QUAD_ENTRY 8'h38
`define OP_QUAD_EXIT 8'hff
`define OP_RESET_ARM 8'h66
`define OP_RESET_GO 8'h99
`define OP_STATUS 8'h05
`define OP_WAKE_ID 8'hab
`define OP_MAKER_ID 8'h90
`define OP_IDENT3 8'h9f

`define DUMMY_NONE 4'h0
`define DUMMY_FAST 4'h8
`define DUMMY_FAST_QUAD 4'h6
`define DUMMY_DUAL_OUT 4'h8
`define DUMMY_DUAL_IO 4'h4
`define DUMMY_QUAD_IO 4'h6
`define DUMMY_QUAD_OUT 4'h8
`define IND_CLOCKS 4'h2
`define ENH_KEEP_NIB 4'ha

`define CMD_CLK_SINGLE 5'h08
`define CMD_CLK_QUAD 5'h02
`define ADDR_CLK_X1 5'h18
`define ADDR_CLK_X2 5'h0c
`define ADDR_CLK_X4 5'h06
`define EXIT_ENH_CLK 5'h02
`define SCLK_HALF 8'h04

`endif

// ===== src/spi_flash_pkg.sv
// types and shared decode for both ends of the serial flash link
// assumes spi_flash_regs.svh is on the include path
`include "spi_flash_regs.svh"

package spi_flash_pkg;

  typedef struct packed {
    logic ok;
    logic has_addr;
    logic has_data;
    logic [2:0] aw;
    logic [2:0] dw;
    logic [3:0] dummy;
  } fmt_t;

  // frame layout of an opcode given the current command mode
  function automatic fmt_t cmd_fmt(input logic [7:0] op, input logic quad);
    fmt_t f;
    f.ok = 1'b1;
    f.has_addr = 1'b0;
    f.has_data = 1'b0;
    f.aw = quad ? 3'h4 : 3'h1;
    f.dw = quad ? 3'h4 : 3'h1;
    f.dummy = `DUMMY_NONE;
    unique case (op)
      `OP_READ: begin
        f.ok = !quad;
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
      end
      `OP_FAST: begin
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
        f.dummy = quad ? `DUMMY_FAST_QUAD : `DUMMY_FAST;
      end
      `OP_DUAL_OUT: begin
        f.ok = !quad;
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
        f.dw = 3'h2;
        f.dummy = `DUMMY_DUAL_OUT;
      end
      `OP_DUAL_IO: begin
        f.ok = !quad;
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
        f.aw = 3'h2;
        f.dw = 3'h2;
        f.dummy = `DUMMY_DUAL_IO;
      end
      `OP_QUAD_IO: begin
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
        f.aw = 3'h4;
        f.dw = 3'h4;
        f.dummy = `DUMMY_QUAD_IO;
      end
      `OP_QUAD_OUT: begin
        f.ok = !quad;
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
        f.dw = 3'h4;
        f.dummy = `DUMMY_QUAD_OUT;
      end
      `OP_QUAD_PROG: f.ok = !quad;
      `OP_STATUS, `OP_IDENT3: f.has_data = 1'b1;
      `OP_WAKE_ID, `OP_MAKER_ID: begin
        f.has_addr = 1'b1;
        f.has_data = 1'b1;
      end
      default: f.ok = 1'b1;
    endcase
    return f;
  endfunction : cmd_fmt

  // msb first; quad nibble is lanes 3..0 = bits 7..4 then 3..0
  function automatic logic [7:0] shift_in(input logic [7:0] sr,
                                          input logic [3:0] io,
                                          input logic [2:0] w);
    unique case (w)
      3'h1: return {sr[6:0], io[0]};
      3'h2: return {sr[5:0], io[1:0]};
      default: return {sr[3:0], io[3:0]};
    endcase
  endfunction : shift_in

  function automatic logic [3:0] lane_mask(input logic [2:0] w);
    unique case (w)
      3'h1: return 4'h2;
      3'h2: return 4'h3;
      default: return 4'hf;
    endcase
  endfunction : lane_mask

endpackage : spi_flash_pkg

// ===== src/spi_link_if.sv
// the four-lane serial link between host controller and flash end
// assumes each party drives only its own out/oe lanes; idle lanes pull up
interface spi_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  logic [3:0] io;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = d_oe[i] ? d_out[i] : (h_oe[i] ? h_out[i] : 1'b1);
    end
  end

  modport device (input sclk, input cs_n, input io,
                  output d_out, output d_oe);
  modport host (output sclk, output cs_n, output h_out, output h_oe,
                input io);
endinterface : spi_link_if

// ===== src/flash_end.sv
// flash end: read-type command decoder running on the link clock
// assumes sclk from the host (modes 0/3); clk/rst is the user-side domain
`include "spi_flash_regs.svh"

// What this block does
// RULE_01 - opcode is eight clocks, two in quad
// RULE_02 - reset runs only right after reset arm
// RULE_03 - msb first, read data on serial output
// RULE_04 - status byte repeats while select low
// RULE_05 - quad byte two clocks, high nibble first
// RULE_06 - wake identifier repeats part code
// RULE_07 - maker/part alternate, address bit picks start
// RULE_08 - three byte id: maker, type, capacity
// RULE_09 - 24-bit address, per-opcode dummy clocks
// RULE_10 - dual reads: byte per four clocks, increment
// RULE_11 - quad reads: byte per two clocks, increment
// RULE_12 - fast read six dummies in quad mode
// RULE_13 - first two quad dummies carry enhance indicator
// RULE_14 - quad entry makes later opcodes four-lane
// RULE_15 - quad mode refuses single/dual reads, program
// RULE_16 - exit opcode returns to single lane
// RULE_17 - host never sends exit in single mode unless enhance mode is on
// RULE_18 - exit opcode also releases enhance mode
// RULE_19 - in enhance and quad, two exits needed
// RULE_20 - sample on rising, drive on falling edge
module flash_end #(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h2c, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40, // arbitrary value
  parameter logic [7:0] MEM_CAP = 8'h07 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] status_in,
  spi_link_if.device link,
  output logic quad_mode,
  output logic enhance_mode,
  output logic soft_reset
);

  typedef enum {D_CMD, D_ADDR, D_DUMMY, D_DATA, D_IGNORE} dstate_t;

  // stand-in for the array: a fixed pattern of the address
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16];
  endfunction : mem_byte

  dstate_t st_r;
  logic [7:0] sr_r;
  logic [2:0] bitcnt_r;
  logic [7:0] op_r;
  spi_flash_pkg::fmt_t fmt_r;
  logic [1:0] abyte_r;
  logic [3:0] dcnt_r;
  logic [7:0] ind_r;
  logic [23:0] addr_r;
  logic [2:0] ocnt_r;
  logic [1:0] idx_r;
  logic qpi_r;
  logic enh_r;
  logic arm_r;
  logic tgl_r;
  logic [3:0] out_r;
  logic [3:0] oe_r;
  logic [7:0] stat_s1_r;
  logic [7:0] stat_s2_r;
  logic [7:0] status_r;
  logic qpi_s1_r;
  logic enh_s1_r;
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;

  // *************************************************************
  // frame decode
  // *************************************************************
  wire frame_rst = link.cs_n | rst;
  wire [2:0] in_w = (st_r == D_CMD) ?
                    ((qpi_r | enh_r) ? 3'h4 : 3'h1) : // RULE_01
                    (st_r == D_ADDR) ? fmt_r.aw : 3'h4;
  wire [7:0] new_byte = spi_flash_pkg::shift_in(sr_r, link.io, in_w); // RULE_03
  wire [3:0] in_sum = {1'b0, bitcnt_r} + {1'b0, in_w};
  wire byte_done = in_sum[3];
  wire cmd_done = (st_r == D_CMD) && !enh_r && byte_done;
  wire enh_done = (st_r == D_CMD) && enh_r && byte_done;
  spi_flash_pkg::fmt_t fnew;
  assign fnew = spi_flash_pkg::cmd_fmt(new_byte, qpi_r);
  wire dummy_last = (st_r == D_DUMMY) && (dcnt_r == fmt_r.dummy - 4'h1);
  wire ind_clock = (st_r == D_DUMMY) && (op_r == `OP_QUAD_IO) &&
                   (dcnt_r < `IND_CLOCKS);
  wire [3:0] out_sum = {1'b0, ocnt_r} + {1'b0, fmt_r.dw};
  wire out_wrap = (st_r == D_DATA) && out_sum[3];
  wire [1:0] idx_nxt = (idx_r == 2'h2) ? 2'h0 : idx_r + 2'h1;

  logic [7:0] cur_byte;
  always_comb begin
    unique case (op_r)
      `OP_STATUS: cur_byte = stat_s2_r; // RULE_04
      `OP_WAKE_ID: cur_byte = PART_ID; // RULE_06
      `OP_MAKER_ID: cur_byte = addr_r[0] ? PART_ID : MAKER_ID; // RULE_07
      `OP_IDENT3: cur_byte = (idx_r == 2'h0) ? MAKER_ID : // RULE_08
                             (idx_r == 2'h1) ? MEM_TYPE : MEM_CAP;
      default: cur_byte = mem_byte(addr_r);
    endcase
  end

  wire [7:0] out_sh = cur_byte << ocnt_r;
  wire [3:0] out_lanes = (fmt_r.dw == 3'h1) ? {2'h0, out_sh[7], 1'b0} :
                         (fmt_r.dw == 3'h2) ? {2'h0, out_sh[7:6]} :
                         out_sh[7:4];

  // *************************************************************
  // per-frame state, cleared while select is high
  // *************************************************************
  always_ff @(posedge link.sclk or posedge frame_rst) begin // RULE_20
    if (frame_rst) begin
      st_r <= D_CMD;
      sr_r <= 8'h00;
      bitcnt_r <= 3'h0;
      op_r <= 8'h00;
      fmt_r <= '0;
      abyte_r <= 2'h0;
      dcnt_r <= 4'h0;
      ind_r <= 8'h00;
      addr_r <= 24'h000000;
      ocnt_r <= 3'h0;
      idx_r <= 2'h0;
    end else begin
      unique case (st_r)
        D_CMD: begin
          sr_r <= new_byte;
          bitcnt_r <= in_sum[2:0];
          if (enh_done) begin
            // enhance frame: opcode is implied, first byte is address
            op_r <= `OP_QUAD_IO;
            fmt_r <= spi_flash_pkg::cmd_fmt(`OP_QUAD_IO, qpi_r);
            addr_r <= {16'h0000, new_byte};
            abyte_r <= 2'h1;
            st_r <= (new_byte == `OP_QUAD_EXIT) ? D_IGNORE : D_ADDR; // RULE_18
          end else if (cmd_done) begin
            op_r <= new_byte;
            fmt_r <= fnew;
            st_r <= !fnew.ok ? D_IGNORE : // RULE_15
                    fnew.has_addr ? D_ADDR :
                    fnew.has_data ? D_DATA : D_IGNORE;
          end
        end
        D_ADDR: begin
          sr_r <= new_byte;
          bitcnt_r <= in_sum[2:0];
          if (byte_done) begin
            addr_r <= {addr_r[15:0], new_byte}; // RULE_09
            abyte_r <= abyte_r + 2'h1;
            if (abyte_r == 2'h2) begin
              st_r <= (fmt_r.dummy != `DUMMY_NONE) ? D_DUMMY : D_DATA;
            end
          end
        end
        D_DUMMY: begin
          dcnt_r <= dcnt_r + 4'h1;
          if (ind_clock) begin
            ind_r <= spi_flash_pkg::shift_in(ind_r, link.io, 3'h4); // RULE_13
          end
          if (dummy_last) begin
            st_r <= D_DATA; // RULE_12
          end
        end
        D_DATA: begin
          ocnt_r <= out_sum[2:0]; // RULE_05
          if (out_wrap) begin
            addr_r <= addr_r + 24'h000001; // RULE_10 RULE_11
            idx_r <= idx_nxt;
          end
        end
        D_IGNORE: st_r <= D_IGNORE;
      endcase
    end
  end

  // *************************************************************
  // mode state, kept across frames
  // *************************************************************
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      qpi_r <= 1'b0;
      enh_r <= 1'b0;
      arm_r <= 1'b0;
      tgl_r <= 1'b0;
    end else if (cmd_done) begin
      arm_r <= (new_byte == `OP_RESET_ARM); // RULE_02
      if (new_byte == `OP_QUAD_ENTRY) begin
        qpi_r <= 1'b1; // RULE_14
      end else if (new_byte == `OP_QUAD_EXIT) begin
        qpi_r <= 1'b0; // RULE_16 RULE_19
      end else if (new_byte == `OP_RESET_GO && arm_r) begin
        qpi_r <= 1'b0; // RULE_02
        enh_r <= 1'b0;
        tgl_r <= ~tgl_r;
      end
    end else if (enh_done && new_byte == `OP_QUAD_EXIT) begin
      enh_r <= 1'b0; // RULE_18 RULE_19
    end else if (dummy_last && op_r == `OP_QUAD_IO) begin
      enh_r <= (ind_r[7:4] == `ENH_KEEP_NIB); // RULE_13
    end
  end

  // status word is quasi-static; a change mid-byte may show torn bits
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      stat_s1_r <= 8'h00;
      stat_s2_r <= 8'h00;
    end else begin
      stat_s1_r <= status_r;
      stat_s2_r <= stat_s1_r;
    end
  end

  // *************************************************************
  // output lanes change on the falling edge
  // *************************************************************
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end else if (st_r == D_DATA) begin
      out_r <= out_lanes; // RULE_20 RULE_03 RULE_05
      oe_r <= spi_flash_pkg::lane_mask(fmt_r.dw);
    end else begin
      out_r <= 4'h0;
      oe_r <= 4'h0;
    end
  end

  assign link.d_out = out_r;
  assign link.d_oe = oe_r;

  // *************************************************************
  // user-side domain
  // *************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= 8'h00;
      qpi_s1_r <= 1'b0;
      enh_s1_r <= 1'b0;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
      quad_mode <= 1'b0;
      enhance_mode <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      status_r <= status_in;
      qpi_s1_r <= qpi_r;
      enh_s1_r <= enh_r;
      tgl_s1_r <= tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      quad_mode <= qpi_s1_r;
      enhance_mode <= enh_s1_r;
      soft_reset <= tgl_s3_r ^ tgl_s2_r; // RULE_02
    end
  end

endmodule : flash_end

// ===== src/flash_host.sv
// host end: builds one framed command per request, divides clk to sclk
// assumes the flash end sits on the other modport of spi_link_if
`include "spi_flash_regs.svh"

module flash_host #(
  parameter logic [7:0] HALF = `SCLK_HALF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [7:0] req_op,
  input wire logic [23:0] req_addr,
  input wire logic [7:0] req_len,
  input wire logic req_keep_enh,
  spi_link_if.host link,
  output logic busy,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic refused,
  output logic quad_mode,
  output logic enhance_mode
);

  typedef enum {H_IDLE, H_CMD, H_ADDR, H_DUMMY, H_DATA, H_END} hstate_t;

  hstate_t st_r;
  logic [7:0] pc_r;
  logic sclk_r;
  logic cs_n_r;
  logic [3:0] out_r;
  logic [3:0] oe_r;
  logic [39:0] tx_r;
  logic [4:0] rem_r;
  logic [3:0] dcnt_r;
  logic [7:0] op_r;
  spi_flash_pkg::fmt_t fmt_r;
  logic [7:0] len_r;
  logic [7:0] rx_r;
  logic arm_r;
  logic [3:0] io_s1_r;
  logic [3:0] io_s2_r;
  logic cmd_quad_r;

  wire rise = (st_r != H_IDLE) && (pc_r == HALF);
  wire fall = (st_r != H_IDLE) && (pc_r == 8'h00);
  wire last_pc = (pc_r == HALF + HALF - 8'h01);
  wire ind_clk = (st_r == H_DUMMY) && (op_r == `OP_QUAD_IO) &&
                 (dcnt_r < `IND_CLOCKS);
  // opcode width is frozen at accept; the mode mirror flips right then
  wire [2:0] cur_w = (st_r == H_CMD) ? (cmd_quad_r ? 3'h4 : 3'h1) :
                     (st_r == H_ADDR) ? fmt_r.aw :
                     (st_r == H_DATA) ? fmt_r.dw : 3'h4;
  wire [39:0] tx_sh = (cur_w == 3'h1) ? {tx_r[38:0], 1'b0} :
                      (cur_w == 3'h2) ? {tx_r[37:0], 2'h0} :
                      {tx_r[35:0], 4'h0};
  wire [3:0] tx_lanes = (cur_w == 3'h1) ? {3'h0, tx_r[39]} :
                        (cur_w == 3'h2) ? {2'h0, tx_r[39:38]} : tx_r[39:36];
  // host sends single-lane bits on lane 0, the flash answers on lane 1
  wire [3:0] tx_mask = (cur_w == 3'h1) ? 4'h1 :
                       spi_flash_pkg::lane_mask(cur_w);
  wire drive = (st_r == H_CMD) || (st_r == H_ADDR) || ind_clk;
  wire [3:0] rx_io = (fmt_r.dw == 3'h1) ? {3'h0, io_s2_r[1]} : io_s2_r;
  wire [7:0] rx_nxt = spi_flash_pkg::shift_in(rx_r, rx_io, fmt_r.dw);
  wire [4:0] byte_clk = (fmt_r.dw == 3'h1) ? 5'h08 :
                        (fmt_r.dw == 3'h2) ? 5'h04 : 5'h02;
  wire [4:0] addr_clk = (fmt_r.aw == 3'h1) ? `ADDR_CLK_X1 :
                        (fmt_r.aw == 3'h2) ? `ADDR_CLK_X2 : `ADDR_CLK_X4;
  wire exit_bad = (req_op == `OP_QUAD_EXIT) && !quad_mode && !enhance_mode;
  wire [7:0] ind = req_keep_enh ? {`ENH_KEEP_NIB, 4'h0} : 8'h00;
  spi_flash_pkg::fmt_t freq;
  assign freq = spi_flash_pkg::cmd_fmt(enhance_mode ? `OP_QUAD_IO : req_op,
                                       quad_mode);

  // *************************************************************
  // frame sequencer
  // *************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= H_IDLE;
      pc_r <= 8'h00;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      out_r <= 4'h0;
      oe_r <= 4'h0;
      tx_r <= 40'h0;
      rem_r <= 5'h00;
      dcnt_r <= 4'h0;
      op_r <= 8'h00;
      fmt_r <= '0;
      len_r <= 8'h00;
      rx_r <= 8'h00;
      arm_r <= 1'b0;
      cmd_quad_r <= 1'b0;
      busy <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      refused <= 1'b0;
      quad_mode <= 1'b0;
      enhance_mode <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      pc_r <= (st_r == H_IDLE || last_pc) ? 8'h00 : pc_r + 8'h01;
      if (st_r == H_IDLE && req && exit_bad) begin
        refused <= 1'b1; // RULE_17
      end else if (st_r == H_IDLE && req) begin
        busy <= 1'b1;
        cs_n_r <= 1'b0;
        op_r <= enhance_mode ? `OP_QUAD_IO : req_op;
        fmt_r <= freq;
        len_r <= req_len;
        arm_r <= (req_op == `OP_RESET_ARM);
        cmd_quad_r <= quad_mode;
        if (enhance_mode) begin
          st_r <= H_ADDR;
          tx_r <= (req_op == `OP_QUAD_EXIT) ? {8'hff, 32'h0} :
                  {req_addr, ind, 8'h00};
          rem_r <= (req_op == `OP_QUAD_EXIT) ? `EXIT_ENH_CLK : `ADDR_CLK_X4;
          if (req_op == `OP_QUAD_EXIT) begin
            op_r <= `OP_QUAD_EXIT;
            enhance_mode <= 1'b0; // RULE_18 RULE_19
          end else begin
            enhance_mode <= req_keep_enh;
          end
        end else begin
          st_r <= H_CMD;
          tx_r <= {req_op, req_addr, ind};
          rem_r <= quad_mode ? `CMD_CLK_QUAD : `CMD_CLK_SINGLE; // RULE_01
          if (req_op == `OP_QUAD_ENTRY) begin
            quad_mode <= 1'b1;
          end else if (req_op == `OP_QUAD_EXIT) begin
            quad_mode <= 1'b0; // RULE_16
          end else if (req_op == `OP_RESET_GO && arm_r) begin
            quad_mode <= 1'b0;
          end else if (req_op == `OP_QUAD_IO && freq.ok) begin
            enhance_mode <= req_keep_enh; // RULE_13
          end
        end
      end else if (fall) begin
        sclk_r <= 1'b0;
        out_r <= tx_lanes; // RULE_03 RULE_05
        oe_r <= drive ? tx_mask : 4'h0;
        if (st_r == H_END) begin
          cs_n_r <= 1'b1;
          oe_r <= 4'h0;
          busy <= 1'b0;
          done <= 1'b1;
          st_r <= H_IDLE;
        end
      end else if (rise) begin
        sclk_r <= 1'b1;
        rem_r <= rem_r - 5'h01;
        if (st_r != H_DATA) begin
          tx_r <= tx_sh;
        end
        if (st_r == H_DUMMY) begin
          dcnt_r <= dcnt_r + 4'h1;
        end
        if (st_r == H_DATA) begin
          rx_r <= rx_nxt;
        end
        if (rem_r == 5'h01) begin
          unique case (st_r)
            H_CMD: begin
              rem_r <= addr_clk; // RULE_09
              // refused opcodes still run; the flash end leaves lanes idle
              st_r <= fmt_r.has_addr ? H_ADDR :
                      (fmt_r.has_data && len_r != 8'h00) ? H_DATA : H_END;
              if (!fmt_r.has_addr) begin
                rem_r <= byte_clk;
              end
            end
            H_ADDR: begin
              dcnt_r <= 4'h0;
              rem_r <= (fmt_r.dummy != `DUMMY_NONE) ?
                       {1'b0, fmt_r.dummy} : byte_clk; // RULE_12
              st_r <= (op_r == `OP_QUAD_EXIT || len_r == 8'h00) ? H_END :
                      (fmt_r.dummy != `DUMMY_NONE) ? H_DUMMY : H_DATA;
            end
            H_DUMMY: begin
              rem_r <= byte_clk;
              st_r <= H_DATA;
            end
            H_DATA: begin
              rd_valid <= 1'b1; // RULE_10 RULE_11
              rd_data <= rx_nxt;
              rem_r <= byte_clk;
              len_r <= len_r - 8'h01;
              if (len_r == 8'h01) begin
                st_r <= H_END;
              end
            end
            default: st_r <= st_r;
          endcase
        end
      end
    end
  end

  // device lanes change on its own sclk edge, so resample first
  always_ff @(posedge clk) begin
    if (rst) begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      io_s1_r <= link.io;
      io_s2_r <= io_s1_r;
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.h_out = out_r;
  assign link.h_oe = oe_r;

endmodule : flash_host

// ===== tb/link_checker.sv
// assertions on the four-lane link between the host and flash ends
// assumes sclk is divided from clk, four clk cycles per half period
module link_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_out,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_out,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] io
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************
  // frame tracking
  // ****************
  logic sclk_q_r;
  logic single_r;
  logic [5:0] rises_r;
  wire rise = sclk & ~sclk_q_r;
  // lane width of the first clock tells single from quad framing
  always_ff @(posedge clk) begin
    sclk_q_r <= sclk;
    if (rise && rises_r == 6'h00) single_r <= (h_oe == 4'h1);
  end
  always_ff @(posedge clk) begin
    if (rst || cs_n) rises_r <= 6'h00;
    else if (rise && rises_r != 6'h3f) rises_r <= rises_r + 6'h01;
  end
  lane_contention_a: assert property ((d_oe & h_oe) == 4'h0)
    else $error("both ends drive one lane");
  sclk_idle_low_a: assert property (cs_n |-> !sclk)
    else $error("link clock high while deselected");
  deselect_release_a: assert property (cs_n |-> d_oe == 4'h0)
    else $error("flash drives while deselected");
  sclk_high_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high time wrong");
  drive_on_fall_a: assert property (
    !cs_n && $past(cs_n) == 1'b0 && $changed({d_oe, d_out}) |-> !sclk)
    else $error("flash output moved while clock high");
  quiet_opcode_a: assert property (rises_r < 6'h02 |-> d_oe == 4'h0)
    else $error("flash drives inside opcode");
  single_opcode_a: assert property (
    single_r && rises_r != 6'h00 && rises_r < 6'h08
    |-> h_oe == 4'h1 && d_oe == 4'h0)
    else $error("single opcode not on lane 0");
  serial_out_a: assert property (d_oe[1] |-> io[1] == d_out[1])
    else $error("serial output lane not carrying flash data");
  first_width_a: assert property (
    rise && rises_r == 6'h00 |-> h_oe == 4'h1 || h_oe == 4'hf)
    else $error("opcode lane width wrong");
  cover property ($rose(d_oe[1]));
  cover property (d_oe == 4'hf);
  cover property (rise && rises_r == 6'h00 && h_oe == 4'hf);
endmodule : link_checker

// ===== tb/serial_flash_read_qpi_front_end_bench.sv
// bench joining host and flash ends through one link interface
// assumes the design files and spi_flash_regs.svh are compiled first
module serial_flash_read_qpi_front_end_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [7:0] op = 8'h00;
  logic [23:0] adr = 24'h000000;
  logic [7:0] len = 8'h00;
  logic keep = 1'b0;
  logic [7:0] status_in = 8'h3c;
  logic busy, rd_valid, done, refused, h_quad, h_enh;
  logic d_quad, d_enh, soft_reset, was_ref;
  logic [7:0] rd_data;
  logic [7:0] got[$];
  logic [7:0] rd_ops[6] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'heb, 8'h6b};
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int resets = 0;
  spi_link_if link ();
  flash_host flash_host_i (.clk(clk), .rst(rst), .req(req), .req_op(op),
    .req_addr(adr), .req_len(len), .req_keep_enh(keep), .link(link),
    .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .refused(refused), .quad_mode(h_quad), .enhance_mode(h_enh));
  flash_end flash_end_i (.clk(clk), .rst(rst), .status_in(status_in),
    .link(link), .quad_mode(d_quad), .enhance_mode(d_enh),
    .soft_reset(soft_reset));
  link_checker link_checker_i (.clk(clk), .rst(rst), .sclk(link.sclk),
    .cs_n(link.cs_n), .h_out(link.h_out), .h_oe(link.h_oe),
    .d_out(link.d_out), .d_oe(link.d_oe), .io(link.io));
  always #2.5 clk = ~clk;
  // ****************
  // capture and tasks
  // ****************
  always @(posedge clk) begin
    if (rd_valid === 1'b1) got.push_back(rd_data);
    if (soft_reset === 1'b1) resets++;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  // one framed request; waits for done or an immediate refusal
  task automatic issue(input logic [7:0] o, input logic [23:0] a,
    input logic [7:0] n, input logic k);
    int w;
    got.delete();
    @(posedge clk);
    req <= 1'b1;
    op <= o;
    adr <= a;
    len <= n;
    keep <= k;
    @(posedge clk);
    req <= 1'b0;
    #1;
    w = 0;
    while (done !== 1'b1 && refused !== 1'b1 && w < 9000) begin
      @(posedge clk);
      #1;
      w++;
    end
    if (w >= 9000) begin
      mismatches++;
      wrap_up();
    end
    was_ref = (refused === 1'b1);
    // mode flags cross two flops before they show
    repeat (4) @(posedge clk);
  endtask : issue
  task automatic cmd(input logic [7:0] o);
    issue(o, 24'h000000, 8'h00, 1'b0);
  endtask : cmd
  task automatic chk_id(input logic [31:0] e, input int n);
    chk("count", n[7:0], 8'(got.size()));
    for (int i = 0; i < n; i++) begin
      chk("id byte", e[31 - 8 * i -: 8], got[i]);
    end
  endtask : chk_id
  task automatic chk_rd(input logic [23:0] a, input int n);
    logic [23:0] b;
    chk("count", n[7:0], 8'(got.size()));
    for (int i = 0; i < n; i++) begin
      b = a + 24'(i);
      chk("read byte", b[7:0] ^ b[15:8] ^ b[23:16], got[i]);
    end
  endtask : chk_rd
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    issue(8'h9f, 24'h000000, 8'h04, 1'b0);
    chk_id(32'h5a40075a, 4);
    chk("busy idle", 8'h00, {7'h00, busy});
    issue(8'h05, 24'h000000, 8'h03, 1'b0);
    chk_id(32'h3c3c3c00, 3);
    issue(8'hab, 24'h000000, 8'h02, 1'b0);
    chk_id(32'h2c2c0000, 2);
    issue(8'h90, 24'h000000, 8'h03, 1'b0);
    chk_id(32'h5a2c5a00, 3);
    issue(8'h90, 24'h000001, 8'h03, 1'b0);
    chk_id(32'h2c5a2c00, 3);
    foreach (rd_ops[i]) begin
      issue(rd_ops[i], 24'h12345c + 24'(i), 8'h03, 1'b0);
      chk_rd(24'h12345c + 24'(i), 3);
    end
    cmd(8'h38);
    chk("quad on", 8'h03, {6'h00, d_quad, h_quad});
    issue(8'h0b, 24'h00ff02, 8'h02, 1'b0);
    chk_rd(24'h00ff02, 2);
    issue(8'h05, 24'h000000, 8'h02, 1'b0);
    chk_id(32'h3c3c0000, 2);
    issue(8'h03, 24'h000000, 8'h01, 1'b0);
    chk("ignored count", 8'h01, 8'(got.size()));
    foreach (got[i]) chk("ignored read", 8'hff, got[i]);
    issue(8'heb, 24'h0abcde, 8'h02, 1'b1);
    chk_rd(24'h0abcde, 2);
    chk("enhance on", 8'h03, {6'h00, d_enh, h_enh});
    issue(8'heb, 24'h000010, 8'h01, 1'b1);
    chk_rd(24'h000010, 1);
    cmd(8'hff);
    chk("first exit", 8'h0a, {4'h0, d_quad, d_enh, h_quad, h_enh});
    cmd(8'hff);
    chk("second exit", 8'h00, {4'h0, d_quad, d_enh, h_quad, h_enh});
    cmd(8'hff);
    chk("exit refused", 8'h01, {7'h00, was_ref});
    issue(8'heb, 24'h000020, 8'h01, 1'b1);
    cmd(8'hff);
    chk("single exit", 8'h00, {6'h00, d_enh, was_ref});
    cmd(8'h38);
    cmd(8'h66);
    issue(8'h05, 24'h000000, 8'h01, 1'b0);
    cmd(8'h99);
    chk("reset disarmed", 8'h01, {7'h00, d_quad});
    chk("no reset", 8'h00, 8'(resets));
    cmd(8'h66);
    cmd(8'h99);
    chk("reset done", 8'h00, {7'h00, d_quad});
    chk("reset pulse", 8'h01, 8'(resets));
    wrap_up();
  end
endmodule : serial_flash_read_qpi_front_end_bench
